/* File: pkg/ccd_seq_pkg.sv */
`default_nettype none
package ccd_seq_pkg;
	localparam int CLK_MHZ          = 200;
	localparam int T_SHUTTER_NS     = 2000;
	localparam int T_PD_XFER_NS     = 6000;
	localparam int T_VSHIFT_NS      = 4000;
	localparam int T_EXTENDED_RANGE_BINNING_DUAL_NS   = 124900;
	localparam int T_EXTENDED_RANGE_BINNING_SINGLE_NS = 217400;
	localparam int SHUT_CYC    = (T_SHUTTER_NS * CLK_MHZ + 999) / 1000;
	localparam int XFER_CYC    = (T_PD_XFER_NS * CLK_MHZ + 999) / 1000;
	localparam int VSHIFT_CYC  = (T_VSHIFT_NS * CLK_MHZ + 999) / 1000;
	localparam int XL_DUAL_CYC = (T_EXTENDED_RANGE_BINNING_DUAL_NS * CLK_MHZ + 999) / 1000;
	localparam int XL_SNGL_CYC = (T_EXTENDED_RANGE_BINNING_SINGLE_NS * CLK_MHZ + 999) / 1000;
	localparam int ID_SETTLE_DEF = 1000;
	localparam int LW = 12;
	localparam int PW = 13;
	localparam int CW = 22;

	localparam logic [LW-1:0] NV_FULL_SPLIT = 12'h672;
	localparam logic [LW-1:0] NV_FULL_WHOLE = 12'hCCE;
	localparam logic [LW-1:0] NV_QTR_SPLIT  = 12'h339;
	localparam logic [LW-1:0] NV_QTR_WHOLE  = 12'h667;
	localparam logic [PW-1:0] NH_FULL_HALF  = 13'h09AD;
	localparam logic [PW-1:0] NH_FULL_WHOLE = 13'h134F;
	localparam logic [PW-1:0] NH_QTR_HALF   = 13'h04D6;
	localparam logic [PW-1:0] NH_QTR_WHOLE  = 13'h09A7;

	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
	localparam logic [7:0] ADDR_WINDOW   = 8'h0C;
	localparam logic [7:0] ADDR_TRAIL    = 8'h10;
	localparam logic [7:0] ADDR_SAMPLE   = 8'h14;
	localparam logic [7:0] ADDR_REPEAT   = 8'h18;
	localparam logic [7:0] ADDR_TIMING   = 8'h1C;
	localparam logic [7:0] ADDR_FRAMEOVH = 8'h20;

	localparam int CTRL_START = 0;
	localparam int CTRL_SHUT  = 1;
	localparam int CTRL_CONT  = 2;
	localparam int CTRL_STOP  = 3;
	localparam int CTRL_TYPE  = 4;
	localparam int CTRL_OUT   = 6;
	localparam int CTRL_RES   = 8;
	localparam int ST_BUSY    = 0;
	localparam int ST_CFGERR  = 1;
	localparam int ST_IDDONE  = 2;
	localparam int ST_IDLVL   = 3;
	localparam int ST_FCNT    = 16;
	localparam int HI_FIELD   = 16;
	localparam int DIV_FIELD  = 16;

	localparam logic [15:0] RST_LINE_OVH  = 16'h0FA0;
	localparam logic [7:0]  RST_PIX_DIV   = 8'h05;
	localparam logic [15:0] RST_FRAME_OVH = 16'h1F40;

	typedef enum logic [1:0] {
		OUT_QUAD = 2'h0, OUT_DUAL_AC = 2'h1, OUT_DUAL_AB = 2'h2, OUT_SINGLE = 2'h3
	} outMode_t;
	typedef enum logic [1:0] {
		RES_FULL = 2'h0, RES_QUARTER = 2'h1, RES_EXTENDED_RANGE_BINNING = 2'h2
	} res_t;
	typedef enum logic [1:0] {
		RT_FULL = 2'h0, RT_WINDOW = 2'h1, RT_SUB = 2'h2
	} readType_t;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01, S_SHUT = 8'h02, S_EXPO = 8'h04, S_XFER = 8'h08,
		S_SEG  = 8'h10, S_LOVH = 8'h20, S_LPIX = 8'h40, S_FOVH = 8'h80
	} seqState_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apbReq_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apbRsp_t;
	typedef struct packed {
		logic shutter;
		logic transfer;
		logic vShift;
		logic dumpGatePairOne;
		logic dumpGatePairTwo;
		logic hClk;
		logic pixStrobe;
		logic lineRead;
		logic frameActive;
		logic idSense;
	} sensorPins_t;

	function automatic logic [LW-1:0] nvOf(outMode_t o, res_t r);
		logic split;
		split = (o == OUT_QUAD) || (o == OUT_DUAL_AC);
		if (r == RES_FULL)
			return split ? NV_FULL_SPLIT : NV_FULL_WHOLE;
		return split ? NV_QTR_SPLIT : NV_QTR_WHOLE;
	endfunction

	function automatic logic [PW-1:0] nhOf(outMode_t o, res_t r);
		logic half;
		half = (o == OUT_QUAD) || (o == OUT_DUAL_AB);
		if (r == RES_FULL)
			return half ? NH_FULL_HALF : NH_FULL_WHOLE;
		return half ? NH_QTR_HALF : NH_QTR_WHOLE;
	endfunction
endpackage
`default_nettype wire

/* File: rtl/ccd_readout_sequencer.sv */
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ccd_readout_sequencer
	import ccd_seq_pkg::*;
#(
	parameter int ID_SETTLE_CYC = ID_SETTLE_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire apbReq_t     apbReq,
	output var  apbRsp_t     apbRsp,
	input  wire logic        idResistorLevel,
	output var  sensorPins_t sensorPins
);
	typedef struct packed {
		seqState_t   st;
		logic [CW-1:0] cyc;
		logic [CW-1:0] lenCnt;
		logic [PW-1:0] pix;
		logic [7:0]  div;
		logic [1:0]  segIdx;
		logic [LW-1:0] segLeft;
		logic [LW-1:0] repLeft;
		logic [LW-1:0] linesDone;
		logic        dumpLine;
		logic        startReq;
		logic        stopReq;
		logic        shutterEn;
		logic        contMode;
		readType_t   rtype;
		outMode_t    outMode;
		res_t        res;
		logic [LW-1:0] expLines;
		logic [LW-1:0] lead;
		logic [LW-1:0] win;
		logic [LW-1:0] trail;
		logic [LW-1:0] skip;
		logic [LW-1:0] rd;
		logic [LW-1:0] rep;
		logic [15:0] lineOvh;
		logic [7:0]  pixDiv;
		logic [15:0] frameOvh;
		logic        cfgErr;
		logic [15:0] frameCnt;
		logic [2:0]  idSync;
		logic        idFilt;
		logic        idLevel;
		logic        idDone;
		logic [15:0] idCnt;
		logic [31:0] prdata;
		sensorPins_t pins;
	} ctrlState_t;

	ctrlState_t s_r;
	ctrlState_t s_nxt;

	logic [LW-1:0] nvSel;
	logic [PW-1:0] nhSel;
	logic [CW-1:0] lineCyc;
	logic [13:0]   winSum;
	logic [13:0]   halfNv;
	logic [13:0]   leadWin;
	logic [25:0]   subSum;
	logic          placeOk;
	logic          xldrOk;
	logic          typeOk;
	logic          cfgOk;
	logic          mapped;
	logic [31:0]   rdMux;
	logic          wrEn;

	assign nvSel   = nvOf(s_r.outMode, s_r.res);
	assign nhSel   = nhOf(s_r.outMode, s_r.res);
	assign lineCyc = CW'(s_r.lineOvh) + CW'(nhSel) * CW'(s_r.pixDiv);
	assign winSum  = 14'(s_r.lead) + 14'(s_r.win) + 14'(s_r.trail);
	assign halfNv  = 14'(nvSel >> 1);
	assign leadWin = 14'(s_r.lead) + 14'(s_r.win);
	assign subSum  = 26'(s_r.rep) * (26'(s_r.skip) + 26'(s_r.rd));
	// the vertical register splits in the middle in these modes
	assign placeOk = !(s_r.outMode == OUT_QUAD
		|| s_r.outMode == OUT_DUAL_AC)
		|| leadWin <= halfNv || 14'(s_r.lead) >= halfNv
		|| 14'(s_r.lead) + leadWin == 14'(nvSel);
	assign xldrOk = s_r.res != RES_EXTENDED_RANGE_BINNING
		|| lineCyc >= ((s_r.outMode == OUT_DUAL_AB
		|| s_r.outMode == OUT_SINGLE) ? CW'(XL_SNGL_CYC)
		: CW'(XL_DUAL_CYC));
	always_comb begin
		case (s_r.rtype)
			RT_FULL:   typeOk = 1'b1;
			RT_WINDOW: typeOk = winSum >= 14'(nvSel) && placeOk;
			RT_SUB:    typeOk = subSum >= 26'(nvSel) && s_r.rep != '0;
			default:   typeOk = 1'b0;
		endcase
	end
	assign cfgOk = typeOk && xldrOk && s_r.pixDiv != '0
		&& s_r.lineOvh >= 16'(VSHIFT_CYC);

	function automatic logic [LW-1:0] segLen(ctrlState_t c, logic [1:0] i);
		case (c.rtype)
			RT_WINDOW: segLen = (i == 2'h0) ? c.lead
				: (i == 2'h1) ? c.win : c.trail;
			RT_SUB:    segLen = (i == 2'h0) ? c.skip : c.rd;
			default:   segLen = nvOf(c.outMode, c.res);
		endcase
	endfunction

	function automatic logic segDump(ctrlState_t c, logic [1:0] i);
		case (c.rtype)
			RT_WINDOW: segDump = i != 2'h1;
			RT_SUB:    segDump = i == 2'h0;
			default:   segDump = 1'b0;
		endcase
	endfunction

	// only the first segment length and the repeat count are latched here; later segments read the live registers
	function automatic ctrlState_t frameStart(ctrlState_t c);
		ctrlState_t f;
		f = c;
		f.segIdx    = 2'h0;
		f.segLeft   = segLen(c, 2'h0);
		f.repLeft   = c.rep;
		f.linesDone = '0;
		f.cyc       = '0;
		f.st        = c.shutterEn ? S_SHUT : S_XFER;
		return f;
	endfunction

	always_comb begin
		mapped = 1'b1;
		rdMux  = '0;
		case (apbReq.paddr)
			ADDR_CTRL: begin
				rdMux[CTRL_START]    = s_r.startReq;
				rdMux[CTRL_SHUT]     = s_r.shutterEn;
				rdMux[CTRL_CONT]     = s_r.contMode;
				rdMux[CTRL_STOP]     = s_r.stopReq;
				rdMux[CTRL_TYPE+:2]  = s_r.rtype;
				rdMux[CTRL_OUT+:2]   = s_r.outMode;
				rdMux[CTRL_RES+:2]   = s_r.res;
			end
			ADDR_STATUS: begin
				rdMux[ST_BUSY]       = s_r.st != S_IDLE;
				rdMux[ST_CFGERR]     = s_r.cfgErr;
				rdMux[ST_IDDONE]     = s_r.idDone;
				rdMux[ST_IDLVL]      = s_r.idLevel;
				rdMux[ST_FCNT+:16]   = s_r.frameCnt;
			end
			ADDR_EXPOSURE: rdMux[LW-1:0] = s_r.expLines;
			ADDR_WINDOW: begin
				rdMux[LW-1:0]           = s_r.lead;
				rdMux[HI_FIELD+:LW]     = s_r.win;
			end
			ADDR_TRAIL: rdMux[LW-1:0] = s_r.trail;
			ADDR_SAMPLE: begin
				rdMux[LW-1:0]           = s_r.skip;
				rdMux[HI_FIELD+:LW]     = s_r.rd;
			end
			ADDR_REPEAT: rdMux[LW-1:0] = s_r.rep;
			ADDR_TIMING: begin
				rdMux[15:0]             = s_r.lineOvh;
				rdMux[DIV_FIELD+:8]     = s_r.pixDiv;
			end
			ADDR_FRAMEOVH: rdMux[15:0] = s_r.frameOvh;
			default: mapped = 1'b0;
		endcase
	end

	assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && mapped;
	assign apbRsp.pready  = apbReq.psel && apbReq.penable;
	assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
	assign apbRsp.prdata  = s_r.prdata;
	assign sensorPins     = s_r.pins;

	always_comb begin
		s_nxt = s_r;
		s_nxt.idSync = {s_r.idSync[1:0], idResistorLevel};
		if (s_r.idSync[1] == s_r.idSync[2])
			s_nxt.idFilt = s_r.idSync[2];
		if (!s_r.idDone) begin
			if (s_r.idCnt == 16'(ID_SETTLE_CYC - 1)) begin
				s_nxt.idDone  = 1'b1;
				s_nxt.idLevel = s_r.idFilt;
			end else begin
				s_nxt.idCnt = s_r.idCnt + 16'h0001;
			end
		end
		if (apbReq.psel && !apbReq.penable)
			s_nxt.prdata = rdMux;
		if (wrEn) begin
			case (apbReq.paddr)
				ADDR_CTRL: begin
					s_nxt.startReq  = apbReq.pwdata[CTRL_START]
						&& s_r.st == S_IDLE;
					s_nxt.stopReq   = apbReq.pwdata[CTRL_STOP];
					s_nxt.shutterEn = apbReq.pwdata[CTRL_SHUT];
					s_nxt.contMode  = apbReq.pwdata[CTRL_CONT];
					s_nxt.rtype     =
						readType_t'(apbReq.pwdata[CTRL_TYPE+:2]);
					s_nxt.outMode   =
						outMode_t'(apbReq.pwdata[CTRL_OUT+:2]);
					s_nxt.res       = res_t'(apbReq.pwdata[CTRL_RES+:2]);
				end
				ADDR_STATUS:
					if (apbReq.pwdata[ST_CFGERR])
						s_nxt.cfgErr = 1'b0;
				ADDR_EXPOSURE: s_nxt.expLines = apbReq.pwdata[LW-1:0];
				ADDR_WINDOW: begin
					s_nxt.lead = apbReq.pwdata[LW-1:0];
					s_nxt.win  = apbReq.pwdata[HI_FIELD+:LW];
				end
				ADDR_TRAIL: s_nxt.trail = apbReq.pwdata[LW-1:0];
				ADDR_SAMPLE: begin
					s_nxt.skip = apbReq.pwdata[LW-1:0];
					s_nxt.rd   = apbReq.pwdata[HI_FIELD+:LW];
				end
				ADDR_REPEAT: s_nxt.rep = apbReq.pwdata[LW-1:0];
				ADDR_TIMING: begin
					s_nxt.lineOvh = apbReq.pwdata[15:0];
					s_nxt.pixDiv  = apbReq.pwdata[DIV_FIELD+:8];
				end
				ADDR_FRAMEOVH: s_nxt.frameOvh = apbReq.pwdata[15:0];
				default: ;
			endcase
		end

		case (s_r.st)
			S_IDLE:
				if (s_r.startReq) begin
					s_nxt.startReq = 1'b0;
					if (cfgOk)
						s_nxt = frameStart(s_nxt);
					else
						s_nxt.cfgErr = 1'b1;
				end
			S_SHUT:
				if (s_r.cyc == CW'(SHUT_CYC - 1)) begin
					s_nxt.cyc = '0;
					s_nxt.st  = (s_r.expLines == '0) ? S_XFER : S_EXPO;
				end else begin
					s_nxt.cyc = s_r.cyc + 1'b1;
				end
			S_EXPO:
				if (s_r.cyc == lineCyc - 1'b1) begin
					s_nxt.cyc       = '0;
					s_nxt.linesDone = s_r.linesDone + 1'b1;
					if (s_r.linesDone == s_r.expLines - 1'b1)
						s_nxt.st = S_XFER;
				end else begin
					s_nxt.cyc = s_r.cyc + 1'b1;
				end
			S_XFER:
				if (s_r.cyc == CW'(XFER_CYC - 1)) begin
					s_nxt.cyc = '0;
					s_nxt.st  = S_SEG;
				end else begin
					s_nxt.cyc = s_r.cyc + 1'b1;
				end
			S_SEG:
				if (s_r.segLeft != '0) begin
					s_nxt.st       = S_LOVH;
					s_nxt.cyc      = '0;
					s_nxt.lenCnt   = '0;
					s_nxt.dumpLine = segDump(s_r, s_r.segIdx);
				end else if (s_r.rtype == RT_WINDOW && s_r.segIdx != 2'h2)
						begin
					s_nxt.segIdx  = s_r.segIdx + 2'h1;
					s_nxt.segLeft = segLen(s_r, s_r.segIdx + 2'h1);
				end else if (s_r.rtype == RT_SUB && s_r.segIdx == 2'h0) begin
					s_nxt.segIdx  = 2'h1;
					s_nxt.segLeft = s_r.rd;
				end else if (s_r.rtype == RT_SUB && s_r.repLeft > 1) begin
					s_nxt.segIdx  = 2'h0;
					s_nxt.segLeft = s_r.skip;
					s_nxt.repLeft = s_r.repLeft - 1'b1;
				end else begin
					s_nxt.st  = S_FOVH;
					s_nxt.cyc = '0;
				end
			S_LOVH: begin
				s_nxt.lenCnt = s_r.lenCnt + 1'b1;
				if (s_r.cyc == CW'(s_r.lineOvh) - 1'b1) begin
					s_nxt.segLeft = s_r.segLeft - 1'b1;
					s_nxt.pix     = '0;
					s_nxt.div     = '0;
					// dumped lines skip the horizontal shifts entirely
					s_nxt.st      = s_r.dumpLine ? S_SEG : S_LPIX;
				end else begin
					s_nxt.cyc = s_r.cyc + 1'b1;
				end
			end
			S_LPIX: begin
				s_nxt.lenCnt = s_r.lenCnt + 1'b1;
				if (s_r.div == s_r.pixDiv - 8'h01) begin
					s_nxt.div = '0;
					if (s_r.pix == nhSel - 1'b1)
						s_nxt.st = S_SEG;
					else
						s_nxt.pix = s_r.pix + 1'b1;
				end else begin
					s_nxt.div = s_r.div + 8'h01;
				end
			end
			S_FOVH:
				if (s_r.cyc == CW'(s_r.frameOvh)) begin
					s_nxt.frameCnt = s_r.frameCnt + 16'h0001;
					if (s_r.contMode && !s_r.stopReq && cfgOk) begin
						s_nxt = frameStart(s_nxt);
					end else begin
						s_nxt.st      = S_IDLE;
						s_nxt.stopReq = 1'b0;
					end
				end else begin
					s_nxt.cyc = s_r.cyc + 1'b1;
				end
			default: s_nxt.st = S_IDLE;
		endcase

		s_nxt.pins.shutter  = s_nxt.st == S_SHUT;
		s_nxt.pins.transfer = s_nxt.st == S_XFER;
		s_nxt.pins.vShift   = s_nxt.st == S_LOVH
			&& s_nxt.cyc < CW'(VSHIFT_CYC);
		s_nxt.pins.dumpGatePairOne = s_nxt.st == S_LOVH
			&& s_nxt.dumpLine;
		s_nxt.pins.dumpGatePairTwo = s_nxt.st == S_LOVH
			&& s_nxt.dumpLine;
		s_nxt.pins.hClk      = s_nxt.st == S_LPIX
			&& s_nxt.div < ((s_nxt.pixDiv + 8'h01) >> 1);
		s_nxt.pins.pixStrobe = s_nxt.st == S_LPIX && s_nxt.div == '0;
		s_nxt.pins.lineRead  = s_nxt.st == S_LPIX;
		s_nxt.pins.frameActive = s_nxt.st != S_IDLE;
		s_nxt.pins.idSense   = !s_nxt.idDone;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s_r          <= '0;
			s_r.st       <= S_IDLE;
			s_r.lineOvh  <= RST_LINE_OVH;
			s_r.pixDiv   <= RST_PIX_DIV;
			s_r.frameOvh <= RST_FRAME_OVH;
			s_r.pins.idSense <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// pulse widths run past the longest plain delay, so count them here
	logic [CW-1:0] shutRun;
	logic [CW-1:0] xferRun;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shutRun <= '0;
			xferRun <= '0;
		end else begin
			shutRun <= sensorPins.shutter ? shutRun + 1'b1 : '0;
			xferRun <= sensorPins.transfer ? xferRun + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_shutter_width;
		$fell(sensorPins.shutter) |-> shutRun == CW'(SHUT_CYC);
	endproperty
	a_shutter_width: assert property (p_shutter_width)
		else $error("shutter pulse width wrong");

	sequence q_xferDone;
		(xferRun == CW'(XFER_CYC) && s_r.st == S_SEG)
			##1 (s_r.st == S_LOVH || s_r.st == S_FOVH || s_r.st == S_SEG);
	endsequence
	property p_transfer_ends;
		$fell(sensorPins.transfer) |-> q_xferDone;
	endproperty
	a_transfer_ends: assert property (p_transfer_ends)
		else $error("transfer pulse length or follow-on wrong");

	property p_expose_lines;
		(s_r.st == S_EXPO && s_nxt.st == S_XFER) |->
			s_r.linesDone + 1'b1 == s_r.expLines;
	endproperty
	a_expose_lines: assert property (p_expose_lines)
		else $error("exposure line count mismatch");

	property p_dump_gate;
		(sensorPins.dumpGatePairOne || sensorPins.dumpGatePairTwo) |->
			(s_r.st == S_LOVH && s_r.dumpLine && !sensorPins.lineRead);
	endproperty
	a_dump_gate: assert property (p_dump_gate)
		else $error("dump gate high outside a dumped line");

	property p_read_segment;
		(sensorPins.pixStrobe && s_r.rtype != RT_FULL) |->
			s_r.segIdx == 2'h1;
	endproperty
	a_read_segment: assert property (p_read_segment)
		else $error("pixels read in a dump segment");

	property p_refuse_bad;
		(s_r.st == S_IDLE && s_r.startReq && !cfgOk) |=>
			(s_r.st == S_IDLE && s_r.cfgErr) [*2];
	endproperty
	a_refuse_bad: assert property (p_refuse_bad)
		else $error("bad configuration started a frame");

	property p_line_period;
		(s_r.st == S_LPIX ##1 s_r.st == S_SEG) |->
			$past(s_r.lenCnt) + 1'b1 == $past(lineCyc);
	endproperty
	a_line_period: assert property (p_line_period)
		else $error("read line period not overhead plus pixels");

	property p_full_count;
		($rose(sensorPins.transfer) && s_r.rtype == RT_FULL) |->
			s_r.segLeft == nvSel;
	endproperty
	a_full_count: assert property (p_full_count)
		else $error("full frame line count not the shift count");

	property p_id_off;
		s_r.idDone |-> !sensorPins.idSense ##1 !sensorPins.idSense;
	endproperty
	a_id_off: assert property (p_id_off)
		else $error("id sensing left on after read");
endmodule
`default_nettype wire

/* File: test/ccd_sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ccd_sensor_model
	import ccd_seq_pkg::*;
#(
	parameter logic ID_LEVEL = 1'b1
) (
	input  wire logic        core_clk,
	input  wire sensorPins_t sensorPins,
	output var  logic        idResistorLevel,
	output var  logic [15:0] dumpedLines,
	output var  logic [15:0] readLines
);
	logic floatBit = 1'b0;
	logic prevShift = 1'b0;
	logic prevRead = 1'b0;
	logic prevDump = 1'b0;
	logic [15:0] dumpCnt = 16'h0000;
	logic [15:0] readCnt = 16'h0000;

	assign dumpedLines = dumpCnt;
	assign readLines = readCnt;

	// sampled mid-cycle, where the pins have settled
	always @(negedge core_clk) begin
		floatBit <= ~floatBit;
		prevShift <= sensorPins.vShift;
		prevRead <= sensorPins.lineRead;
		prevDump <= sensorPins.dumpGatePairOne;
		// gates and shift fall together, so judge by the gate level before
		if (prevShift && !sensorPins.vShift && prevDump)
			dumpCnt <= dumpCnt + 16'h0001;
		if (prevRead && !sensorPins.lineRead)
			readCnt <= readCnt + 16'h0001;
	end

	// with sensing off the pin floats, so the level wanders each cycle
	assign idResistorLevel = sensorPins.idSense ? ID_LEVEL : floatBit;
endmodule
`default_nettype wire

/* File: test/ccd_readout_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ccd_readout_sequencer_tb;
	import ccd_seq_pkg::*;
	localparam int B_SHUT = 9;
	localparam int B_XFER = 8;
	localparam int B_VSH = 7;
	localparam int B_DG1 = 6;
	localparam int B_DG2 = 5;
	localparam int B_LREAD = 2;
	localparam int B_IDS = 0;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	apbReq_t     apbReq = '0;
	apbRsp_t     apbRsp;
	sensorPins_t sensorPins;
	logic        idResistorLevel;
	logic [15:0] dumpedLines;
	logic [15:0] readLines;
	logic [9:0]  pv;
	int          errors = 0;
	int          n_compared = 0;
	int          nvTab[2][4] = '{'{1650, 1650, 3278, 3278}, '{825, 825, 1639, 1639}};
	int          nhTab[2][4] = '{'{2477, 4943, 2477, 4943}, '{1238, 2471, 1238, 2471}};

	// pins are read mid-cycle so no edge race with the design
	always @(negedge core_clk)
		pv <= sensorPins;
	always #2.5 core_clk = ~core_clk;

	ccd_readout_sequencer #(.ID_SETTLE_CYC(8)) dut (
		.core_clk        (core_clk),
		.reset           (reset),
		.apbReq          (apbReq),
		.apbRsp          (apbRsp),
		.idResistorLevel (idResistorLevel),
		.sensorPins      (sensorPins)
	);

	ccd_sensor_model model (
		.core_clk        (core_clk),
		.sensorPins      (sensorPins),
		.idResistorLevel (idResistorLevel),
		.dumpedLines     (dumpedLines),
		.readLines       (readLines)
	);

	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
		n_compared++;
		if (seen !== exp) begin
			$display("unexpected %s expected %0d seen %0d", what, exp, seen);
			errors++;
		end
	endtask

	// every task is entered and left just after a rising edge
	task automatic apbXfer(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] rd, output logic e);
		int n;
		n = 0;
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		@(posedge core_clk);
		while (apbRsp.pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge core_clk);
		end
		if (n >= 50)
			errors++;
		rd = apbRsp.prdata;
		e = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apbXfer(1'b1, a, d, rd, e);
	endtask

	task automatic rdChk(string what, logic [7:0] a, logic [31:0] exp, logic err);
		logic [31:0] rd;
		logic e;
		apbXfer(1'b0, a, 32'h00000000, rd, e);
		chk(what, exp, rd);
		chk("pslverr", 32'(err), 32'(e));
	endtask

	task automatic stChk(logic err, logic busy);
		logic [31:0] rd;
		logic e;
		apbXfer(1'b0, ADDR_STATUS, 32'h00000000, rd, e);
		chk("cfgErr", 32'(err), 32'(rd[ST_CFGERR]));
		chk("busy", 32'(busy), 32'(rd[ST_BUSY]));
	endtask

	task automatic doReset;
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		wr(ADDR_TIMING, 32'h00010320);
	endtask

	task automatic waitBit(int b, logic v, int lim, output int cyc);
		cyc = 0;
		while (pv[b] !== v && cyc < lim) begin
			@(posedge core_clk);
			cyc++;
		end
		if (cyc >= lim) begin
			$display("unexpected pin %0d level %0d never seen", b, v);
			errors++;
		end
	endtask

	task automatic hiWidth(int b, int lim, output int w);
		int g;
		waitBit(b, 1'b1, lim, g);
		waitBit(b, 1'b0, lim, w);
	endtask

	function automatic logic [31:0] ctrl(logic sh, logic [1:0] ty,
		logic [1:0] o, logic [1:0] r);
		return 32'h00000001 | (32'(sh) << CTRL_SHUT) | (32'(ty) << CTRL_TYPE)
			| (32'(o) << CTRL_OUT) | (32'(r) << CTRL_RES);
	endfunction

	task automatic cfgWin(logic sh, logic [1:0] o, logic [1:0] r, int lead,
		int win, int trail);
		wr(ADDR_WINDOW, {4'h0, 12'(win), 4'h0, 12'(lead)});
		wr(ADDR_TRAIL, 32'(trail));
		wr(ADDR_CTRL, ctrl(sh, 2'h1, o, r));
	endtask

	initial begin
		#1000000;
		errors++;
		wrap_up();
	end

	initial begin
		int w;
		int g;
		int nv;
		int lead;
		logic [31:0] rd;
		logic e;
		logic [15:0] dump0;
		logic [15:0] read0;
		int pOut[4] = '{0, 0, 0, 2};
		int pLead[4] = '{400, 0, 400, 0};
		int pWin[4] = '{20, 400, 25, 40};
		logic pErr[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
		void'($urandom(32'h00006C0F));
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rdChk("timing", ADDR_TIMING, 32'h00050FA0, 1'b0);
		rdChk("frameOvh", ADDR_FRAMEOVH, 32'h00001F40, 1'b0);
		rdChk("exposure", ADDR_EXPOSURE, 32'h00000000, 1'b0);
		rdChk("unmapped", 8'h40, 32'h00000000, 1'b1);
		apbXfer(1'b1, 8'h40, 32'hFFFFFFFF, rd, e);
		chk("unmappedWrite", 32'h00000001, 32'(e));
		waitBit(B_IDS, 1'b0, 200, g);
		rdChk("status", ADDR_STATUS, 32'h0000000C, 1'b0);
		// every output mode at full and quarter resolution: shift counts and row length
		for (int r = 0; r < 2; r++) begin
			for (int o = 0; o < 4; o++) begin
				nv = nvTab[r][o];
				doReset();
				cfgWin(1'b0, 2'(o), 2'(r), 0, nv - 1 - $urandom_range(7), 0);
				stChk(1'b1, 1'b0);
				wr(ADDR_STATUS, 32'h00000002);
				stChk(1'b0, 1'b0);
				wr(ADDR_CTRL, ctrl(1'b0, 2'h0, 2'(o), 2'(r)));
				hiWidth(B_XFER, 2000, w);
				chk("transfer", 1200, w);
				hiWidth(B_VSH, 2000, w);
				chk("vShift", 800, w);
				hiWidth(B_LREAD, 6000, w);
				chk("rowPixels", nhTab[r][o], w);
				stChk(1'b0, 1'b1);
			end
		end
		for (int i = 0; i < 4; i++) begin
			nv = nvTab[1][pOut[i]];
			lead = (i == 3) ? 700 + $urandom_range(199) : pLead[i];
			doReset();
			cfgWin(1'b0, 2'(pOut[i]), 2'h1, lead, pWin[i], nv - lead - pWin[i]);
			stChk(pErr[i], !pErr[i]);
		end
		// extended range: short line refused, long line accepted
		doReset();
		wr(ADDR_CTRL, ctrl(1'b0, 2'h0, 2'h0, 2'h2));
		stChk(1'b1, 1'b0);
		wr(ADDR_STATUS, 32'h00000002);
		wr(ADDR_TIMING, 32'h00140320);
		wr(ADDR_CTRL, ctrl(1'b0, 2'h0, 2'h0, 2'h2));
		stChk(1'b0, 1'b1);
		// shuttered window frame with one exposure line
		doReset();
		wr(ADDR_EXPOSURE, 32'h00000001);
		dump0 = dumpedLines;
		read0 = readLines;
		cfgWin(1'b1, 2'h0, 2'h1, 2, 10, 813);
		hiWidth(B_SHUT, 1000, w);
		chk("shutter", SHUT_CYC, w);
		waitBit(B_XFER, 1'b1, 3000, g);
		chk("exposureSpan", 1, 32'(g >= 2038 && g <= 2042));
		waitBit(B_XFER, 1'b0, 2000, w);
		chk("transfer", 1200, w);
		repeat (2) begin
			hiWidth(B_DG1, 2000, w);
			chk("dumpGate", 800, w);
		end
		waitBit(B_LREAD, 1'b1, 3000, g);
		chk("gateInRead", 0, 32'(pv[B_DG1] | pv[B_DG2]));
		waitBit(B_LREAD, 1'b0, 2000, w);
		chk("windowRow", 1238, w);
		@(posedge core_clk);
		chk("dumped", 2, 32'(dumpedLines - dump0));
		chk("read", 1, 32'(readLines - read0));
		// subsampling: skip two, read one
		doReset();
		wr(ADDR_SAMPLE, 32'h00010002);
		wr(ADDR_REPEAT, 32'h00000112);
		wr(ADDR_CTRL, ctrl(1'b0, 2'h2, 2'h0, 2'h1));
		stChk(1'b1, 1'b0);
		wr(ADDR_STATUS, 32'h00000002);
		wr(ADDR_REPEAT, 32'h00000113);
		dump0 = dumpedLines;
		read0 = readLines;
		wr(ADDR_CTRL, ctrl(1'b0, 2'h2, 2'h0, 2'h1));
		stChk(1'b0, 1'b1);
		for (int k = 1; k <= 2; k++) begin
			waitBit(B_LREAD, 1'b1, 8000, g);
			waitBit(B_LREAD, 1'b0, 3000, w);
			@(posedge core_clk);
			chk("skipped", 2 * k, 32'(dumpedLines - dump0));
			chk("sampled", k, 32'(readLines - read0));
		end
		doReset();
		wrap_up();
	end
endmodule
`default_nettype wire
